//--- dv/smpc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module smpc_asserts (
  input wire logic       clk_sys_in,
  input wire logic       rstn_in,
  input wire logic       stop_allow_bit,
  input wire logic       debug_permit_bit,
  input wire logic       lowvolt_detect_on,
  input wire logic       lowvolt_in_stop_on,
  input wire logic       powerdown_select,
  input wire logic       partial_powerdown_select,
  input wire logic       wakeup_pin,
  input wire logic       powerdown_acknowledge,
  input wire logic       cpu_clk_en,
  input wire logic       bus_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       debug_clk_en,
  input wire logic       regulator_full,
  input wire logic       ram_power,
  input wire logic       io_default,
  input wire logic       io_latch_hold,
  input wire logic       por_reset,
  input wire logic       partial_powerdown_wake_flag,
  input wire logic [2:0] mode
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  logic [2:0] pick;
  // Stop entry is the only event that drops the CPU clock enable
  assign pick = !stop_allow_bit ? 3'h0 : debug_permit_bit ? 3'h2 :
    (lowvolt_detect_on && lowvolt_in_stop_on) ? 3'h3 : !powerdown_select ? 3'h1 :
    partial_powerdown_select ? 3'h4 : 3'h5;
  a_mode_sel: assert property ($fell(cpu_clk_en) |-> mode == $past(pick))
    else $error("stop mode differs from selection");
  a_mode_hold: assert property (!cpu_clk_en && !$past(cpu_clk_en) |-> $stable(mode))
    else $error("mode changed while stopped");
  a_clk_halt: assert property (!cpu_clk_en |-> !bus_clk_en && !periph_clk_en)
    else $error("clock left running in stop");
  a_dbg_clk: assert property (!cpu_clk_en |-> (debug_clk_en == (mode == 3'h2)) &&
    (regulator_full == (mode inside {3'h2, 3'h3}))) else $error("debug clock or regulator wrong");
  a_s1_pins: assert property (!cpu_clk_en |-> (io_default == (mode == 3'h5)) &&
    (ram_power == (mode != 3'h5))) else $error("pin default or ram power wrong");
  a_s2_latch: assert property (!cpu_clk_en && mode == 3'h4 |-> io_latch_hold)
    else $error("pins not latched in stop2");
  a_wake_pin: assert property (!cpu_clk_en && mode >= 3'h4 && !wakeup_pin
    |=> por_reset [*8]) else $error("wake pin did not start reset hold");
  a_ppd_hold: assert property (partial_powerdown_wake_flag && !powerdown_acknowledge
    |=> partial_powerdown_wake_flag && io_latch_hold) else $error("stop2 flag or latch dropped");
  c_stop2: cover property (!cpu_clk_en && mode == 3'h4);
  c_por: cover property ($rose(por_reset));
  c_ack: cover property ($fell(partial_powerdown_wake_flag));
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        clk_sys_in;
  logic        rstn_in;
  logic [3:0]  av_a;
  logic        av_rd;
  logic        av_wr;
  logic        av_wait;
  logic        stp_o;
  logic [31:0] av_wd, av_rdata, rdv, ctrl;
  logic [2:0]  mode_o, m;
  logic [5:0]  cfg;
  logic [7:0]  xp;
  logic [5:0]  cor [6];
  int          n_fail, n_checks, k;
  integer      seed;
  smpc_if s ();
  smpc_device u_smpc_device (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(s),
    .mode_out(mode_o), .stopped_out(stp_o));
  smpc_host u_smpc_host (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(s),
    .avs_address_in(av_a), .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wd),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait));
  smpc_asserts u_smpc_asserts (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .stop_allow_bit(s.stop_allow_bit), .debug_permit_bit(s.debug_permit_bit),
    .lowvolt_detect_on(s.lowvolt_detect_on), .lowvolt_in_stop_on(s.lowvolt_in_stop_on),
    .powerdown_select(s.powerdown_select), .partial_powerdown_select(s.partial_powerdown_select),
    .wakeup_pin(s.wakeup_pin), .powerdown_acknowledge(s.powerdown_acknowledge),
    .cpu_clk_en(s.cpu_clk_en), .bus_clk_en(s.bus_clk_en), .periph_clk_en(s.periph_clk_en),
    .debug_clk_en(s.debug_clk_en), .regulator_full(s.regulator_full), .ram_power(s.ram_power),
    .io_default(s.io_default), .io_latch_hold(s.io_latch_hold), .por_reset(s.por_reset),
    .partial_powerdown_wake_flag(s.partial_powerdown_wake_flag), .mode(s.mode));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [2:0] pick(input logic [5:0] c);
    if (!c[0]) return smpc_pkg::SMPC_M_NONE;
    if (c[1]) return smpc_pkg::SMPC_M_S3_DBG;
    if (c[2] && c[3]) return smpc_pkg::SMPC_M_S3_REG;
    if (!c[4]) return smpc_pkg::SMPC_M_S3;
    return c[5] ? smpc_pkg::SMPC_M_S2 : smpc_pkg::SMPC_M_S1;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Waitrequest and read data are taken as they stood at the rising edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys_in);
    av_rd <= ~w;
    av_wr <= w;
    av_a <= a;
    av_wd <= d;
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while (av_wait !== 1'b0 && t < 20);
    if (av_wait !== 1'b0) begin
      n_fail++;
      complete_run();
    end
    rdv = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic wrs(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    // Debug answers reach the status bits one cycle after state does
    @(posedge clk_sys_in);
    acc(1'b0, 4'h8, 32'h0);
  endtask
  // Reset hold keeps the CPU clock on, so wait for run proper
  task automatic wait_cpu;
    int t;
    t = 0;
    do begin
      acc(1'b0, 4'h8, 32'h0);
      t++;
    end while (rdv[8:7] !== 2'b10 && t < 40);
    if (t >= 40) begin
      n_fail++;
      complete_run();
    end
  endtask
  initial begin
    seed = 32'he304;
    n_fail = 0;
    n_checks = 0;
    rstn_in = 1'b0;
    av_a = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    cor = '{6'h11, 6'h31, 6'h01, 6'h3d, 6'h3f, 6'h35};
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    acc(1'b0, 4'h0, 32'h0);
    `CHK("ctrl reset", 32'hc0, rdv)
    acc(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, rdv)
    acc(1'b1, 4'h0, 32'hfe);
    wrs(4'h4, 32'h1);
    acc(1'b0, 4'hc, 32'h0);
    `CHK("illegal stop", 5'h10, {rdv[0], mode_o, stp_o})
    acc(1'b1, 4'hc, 32'h7);
    for (int i = 0; i < 30; i++) begin
      cfg = (i < 6) ? cor[i] : (6'($random(seed)) | 6'h01);
      m = pick(cfg);
      ctrl = 32'hc0 | {26'h0, cfg} | {22'h0, i[0], 9'h0};
      acc(1'b1, 4'h0, ctrl);
      wrs(4'h4, 32'h1);
      `CHK("mode", {m, m, 1'b1}, {rdv[2:0], mode_o, stp_o})
      `CHK("pullup", ctrl[9], rdv[21])
      xp = {m != 5, m == 2 || m == 3, m == 2, 3'h0, m == 5, m == 4};
      `CHK("power", xp, {rdv[13:8], rdv[6:5]})
      if (m == 3'h2) begin
        wrs(4'h4, 32'h14);
        `CHK("memstat", 3'h1, rdv[17:15])
        wrs(4'h4, 32'h04);
        `CHK("mem in stop", 3'h0, rdv[17:15])
        wrs(4'h4, 32'h24);
        `CHK("background", 2'h3, {rdv[16], rdv[8]})
        wrs(4'h4, 32'h34);
        `CHK("active cmd", 1'b1, rdv[16])
        acc(1'b1, 4'h4, 32'h44);
      end else if (m >= 3'h4) begin
        // Low supply on stop1 wake must keep the part in reset
        k = $unsigned($random(seed)) % 2;
        // Wake by pin or by real-time interrupt
        acc(1'b1, 4'h0, (k ? (ctrl | 32'h400) : (ctrl & ~32'h40)) | {23'h0, m == 5, 8'h0});
        if (m == 3'h5) begin
          repeat (6) acc(1'b0, 4'h8, 32'h0);
          `CHK("supply hold", 2'h3, {rdv[14], rdv[7]})
          acc(1'b1, 4'h0, ctrl & ~32'h40);
        end
        wait_cpu();
        xp = {2'h0, m == 5, m == 4, m == 4, 3'h0};
        `CHK("flags", xp, {rdv[4:3], rdv[5], rdv[20:18]})
        acc(1'b1, 4'h0, ctrl);
        wrs(4'h4, 32'h2);
        `CHK("ack", 3'h0, rdv[5:3])
      end else begin
        acc(1'b1, 4'hc, 32'h7);
        k = $unsigned($random(seed)) % 6;
        acc(1'b1, 4'h0, (k == 5) ? ctrl & ~32'h80 : ctrl | (32'h1 << (10 + k)));
        wait_cpu();
        `CHK("vector", (k == 5) ? 3'h0 : 3'(k + 1), rdv[20:18])
        acc(1'b0, 4'hc, 32'h0);
        `CHK("fetch seen", 1'b1, rdv[2])
        acc(1'b1, 4'h0, ctrl);
      end
      $display("case %0d mode %0d done", i, m);
    end
    complete_run();
  end
endmodule
`default_nettype wire

//--- verilog/smpc_device.sv
// Summary of operation
// - Stop disallowed: STOP gives illegal-opcode reset
// - Debug permitted: stop3 with debug clocked
// - Both low-voltage bits set: stop3, regulator on
// - Otherwise powerdown bits pick stop3, stop2, stop1
// - Any stop halts bus and CPU clocks
// - Stop3 keeps registers, RAM and pin states
// - Stop3 ends on reset pin or interrupt
// - Software keeps detector on for ADC in stop3
// - Debug stop keeps debug clock, full regulation
// - Stopped: reject commands except background, status reads report error
// - Background command wakes into background mode
// - Stop2 powers down except RAM, latches pins
// - Wake pin active low, pullup never forced
// - Real-time interrupt wakes stop2 and stop1
// - Stop1/stop2 wake behaves like power-on reset
// - Stop2 wake flag and latches until acknowledge
// - Software restores ports before acknowledging
// - Opened latches follow current port control
// - Stop1 powers down RAM, pins to reset
// - Stop1 wake flag held until acknowledge
// - Software sets port register to all ones
// - Any stop stops peripheral clocks
`timescale 1ns/1ns
`default_nettype none
module smpc_device (
  input  wire logic  clk_sys_in,
  input  wire logic  rstn_in,
  smpc_if.dev        link,
  output logic [2:0] mode_out,
  output logic       stopped_out
);
  smpc_pkg::smpc_state_t state_reg;
  smpc_pkg::smpc_state_t state_next;
  smpc_pkg::smpc_mode_t  mode_reg;
  smpc_pkg::smpc_mode_t  mode_next;
  smpc_pkg::smpc_mode_t  sel_mode;
  logic       ppd_reg;
  logic       ppd_next;
  logic       pd_reg;
  logic       pd_next;
  logic       hold_reg;
  logic       hold_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [2:0] vec_reg;
  logic [2:0] vec_next;
  logic       fetch_reg;
  logic       fetch_next;
  logic       illeg_reg;
  logic       illeg_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       rerr_reg;
  logic       rerr_next;
  logic       rok_reg;
  logic       rok_next;
  logic       rmem_reg;
  logic       rmem_next;
  logic       stopped;
  logic       dbg_live;
  logic [2:0] irq_vec;

  smpc_mode_sel u_sel (
    .stop_allow_in   (link.stop_allow_bit),
    .debug_permit_in (link.debug_permit_bit),
    .lvd_on_in       (link.lowvolt_detect_on),
    .lvd_stop_in     (link.lowvolt_in_stop_on),
    .pd_sel_in       (link.powerdown_select),
    .ppd_sel_in      (link.partial_powerdown_select),
    .mode_out        (sel_mode)
  );

  assign stopped = (state_reg == smpc_pkg::SMPC_STOP3) ||
                   (state_reg == smpc_pkg::SMPC_STOP2) ||
                   (state_reg == smpc_pkg::SMPC_STOP1);
  // Debug logic only answers while it has a clock
  assign dbg_live = !stopped || (mode_reg == smpc_pkg::SMPC_M_S3_DBG);

  // Lowest-numbered pending source takes its vector
  always_comb begin
    irq_vec = smpc_pkg::SMPC_VEC_RESET;
    for (int i = smpc_pkg::SMPC_IRQ_N - 1; i >= 0; i--) begin
      if (link.irq_req[i]) begin
        irq_vec = 3'(i + 1);
      end
    end
  end

  always_comb begin
    state_next  = state_reg;
    mode_next   = mode_reg;
    ppd_next    = ppd_reg;
    pd_next     = pd_reg;
    hold_next   = hold_reg;
    cnt_next    = cnt_reg;
    vec_next    = vec_reg;
    fetch_next  = 1'b0;
    illeg_next  = 1'b0;
    rvalid_next = 1'b0;
    rerr_next   = 1'b0;
    rok_next    = 1'b0;
    rmem_next   = 1'b0;
    // Clear first so a same-cycle set below wins
    if (link.powerdown_acknowledge) begin
      ppd_next  = 1'b0;
      pd_next   = 1'b0;
      hold_next = 1'b0;
    end
    unique case (state_reg)
      smpc_pkg::SMPC_RUN: begin
        if (link.stop_exec) begin
          mode_next = sel_mode;
          unique case (sel_mode)
            smpc_pkg::SMPC_M_NONE: illeg_next = 1'b1;
            smpc_pkg::SMPC_M_S2: begin
              state_next = smpc_pkg::SMPC_STOP2;
              hold_next  = 1'b1;
            end
            smpc_pkg::SMPC_M_S1: state_next = smpc_pkg::SMPC_STOP1;
            default: state_next = smpc_pkg::SMPC_STOP3;
          endcase
        end
      end
      smpc_pkg::SMPC_STOP3: begin
        if (!link.reset_pin_n) begin
          state_next = smpc_pkg::SMPC_PORHOLD;
          cnt_next   = smpc_pkg::SMPC_POR_CYC;
          mode_next  = smpc_pkg::SMPC_M_NONE;
        end else if (|link.irq_req) begin
          state_next = smpc_pkg::SMPC_RUN;
          vec_next   = irq_vec;
          fetch_next = 1'b1;
          mode_next  = smpc_pkg::SMPC_M_NONE;
        end else if (link.dbg_cmd_valid && mode_reg == smpc_pkg::SMPC_M_S3_DBG &&
                     link.dbg_cmd == smpc_pkg::SMPC_DCMD_BKGD) begin
          state_next = smpc_pkg::SMPC_BKGD;
          mode_next  = smpc_pkg::SMPC_M_NONE;
        end
      end
      smpc_pkg::SMPC_STOP2, smpc_pkg::SMPC_STOP1: begin
        if (state_reg == smpc_pkg::SMPC_STOP2) begin
          hold_next = 1'b1;
        end
        // Pin is a wake input here whatever its run-time use
        if (!link.wakeup_pin || link.irq_req[smpc_pkg::SMPC_IRQ_RTI]) begin
          state_next = smpc_pkg::SMPC_PORHOLD;
          cnt_next   = smpc_pkg::SMPC_POR_CYC;
          mode_next  = smpc_pkg::SMPC_M_NONE;
          if (state_reg == smpc_pkg::SMPC_STOP2) begin
            ppd_next = 1'b1;
          end else begin
            pd_next = 1'b1;
          end
        end
      end
      smpc_pkg::SMPC_PORHOLD: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else if (!link.supply_low) begin
          state_next = smpc_pkg::SMPC_RUN;
          vec_next   = smpc_pkg::SMPC_VEC_RESET;
          fetch_next = 1'b1;
        end
      end
      smpc_pkg::SMPC_BKGD: begin
        if (link.dbg_cmd_valid && link.dbg_cmd == smpc_pkg::SMPC_DCMD_GO) begin
          state_next = smpc_pkg::SMPC_RUN;
        end
      end
    endcase
    if (link.dbg_cmd_valid && dbg_live && state_reg != smpc_pkg::SMPC_PORHOLD) begin
      rvalid_next = 1'b1;
      if (stopped) begin
        rerr_next = (link.dbg_cmd == smpc_pkg::SMPC_DCMD_MEMSTAT);
        rok_next  = (link.dbg_cmd == smpc_pkg::SMPC_DCMD_BKGD);
      end else if (state_reg == smpc_pkg::SMPC_BKGD) begin
        rok_next  = 1'b1;
        rmem_next = (link.dbg_cmd == smpc_pkg::SMPC_DCMD_MEM) ||
                    (link.dbg_cmd == smpc_pkg::SMPC_DCMD_MEMSTAT);
      end else begin
        // Run mode takes only non-intrusive commands
        rok_next  = (link.dbg_cmd <= smpc_pkg::SMPC_DCMD_BKGD);
        rmem_next = (link.dbg_cmd == smpc_pkg::SMPC_DCMD_MEM) ||
                    (link.dbg_cmd == smpc_pkg::SMPC_DCMD_MEMSTAT);
        if (link.dbg_cmd == smpc_pkg::SMPC_DCMD_BKGD && link.debug_permit_bit &&
            !link.stop_exec) begin
          state_next = smpc_pkg::SMPC_BKGD;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg  <= smpc_pkg::SMPC_RUN;
      mode_reg   <= smpc_pkg::SMPC_M_NONE;
      ppd_reg    <= 1'b0;
      pd_reg     <= 1'b0;
      hold_reg   <= 1'b0;
      cnt_reg    <= 4'h0;
      vec_reg    <= smpc_pkg::SMPC_VEC_RESET;
      fetch_reg  <= 1'b0;
      illeg_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      rerr_reg   <= 1'b0;
      rok_reg    <= 1'b0;
      rmem_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      mode_reg   <= mode_next;
      ppd_reg    <= ppd_next;
      pd_reg     <= pd_next;
      hold_reg   <= hold_next;
      cnt_reg    <= cnt_next;
      vec_reg    <= vec_next;
      fetch_reg  <= fetch_next;
      illeg_reg  <= illeg_next;
      rvalid_reg <= rvalid_next;
      rerr_reg   <= rerr_next;
      rok_reg    <= rok_next;
      rmem_reg   <= rmem_next;
    end
  end

  // Outputs other than pullup_out decode registered state only; pullup_out passes its input straight through
  assign link.cpu_clk_en     = !stopped;
  assign link.bus_clk_en     = !stopped;
  assign link.periph_clk_en  = !stopped;
  assign link.debug_clk_en   = dbg_live;
  assign link.regulator_full = !stopped || mode_reg == smpc_pkg::SMPC_M_S3_DBG ||
                               mode_reg == smpc_pkg::SMPC_M_S3_REG;
  // Stop3 touches no retained state; only stop1 drops RAM
  assign link.ram_power      = (state_reg != smpc_pkg::SMPC_STOP1);
  assign link.io_latch_hold  = hold_reg;
  assign link.io_default     = (state_reg == smpc_pkg::SMPC_STOP1);
  assign link.por_reset      = (state_reg == smpc_pkg::SMPC_PORHOLD);
  assign link.lvr_low_trip   = (state_reg == smpc_pkg::SMPC_PORHOLD);
  assign link.pullup_out     = link.wakeup_pin_pullup_on;
  assign link.vector_fetch   = fetch_reg;
  assign link.vector_sel     = vec_reg;
  assign link.illegal_reset  = illeg_reg;
  assign link.partial_powerdown_wake_flag = ppd_reg;
  assign link.full_powerdown_wake_flag    = pd_reg;
  assign link.mode           = mode_reg;
  assign link.dbg_resp_valid = rvalid_reg;
  assign link.dbg_resp_err   = rerr_reg;
  assign link.dbg_resp_ok    = rok_reg;
  assign link.dbg_mem_access = rmem_reg;
  assign mode_out            = mode_reg;
  assign stopped_out         = stopped;
endmodule
`default_nettype wire

//--- verilog/smpc_host.sv
`timescale 1ns/1ns
`default_nettype none
module smpc_host (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  smpc_if.host             link,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [2:0]  ev_reg;
  logic [2:0]  ev_next;
  logic [2:0]  resp_reg;
  logic [2:0]  resp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [4:0]  pulse_reg;
  logic [4:0]  pulse_next;
  logic [2:0]  dcmd_reg;
  logic [2:0]  dcmd_next;
  logic        done_reg;
  logic        done_next;
  logic        req;
  logic        wr_go;
  logic [31:0] status;

  assign req   = avs_read_in || avs_write_in;
  // One wait state: every access completes on its second cycle
  assign avs_waitrequest_out = req && !done_reg;
  assign wr_go = avs_write_in && done_reg;

  assign status = {10'h0, link.pullup_out, link.vector_sel, resp_reg,
                   link.lvr_low_trip, link.ram_power, link.regulator_full,
                   link.debug_clk_en, link.periph_clk_en, link.bus_clk_en,
                   link.cpu_clk_en, link.por_reset, link.io_default,
                   link.io_latch_hold, link.full_powerdown_wake_flag,
                   link.partial_powerdown_wake_flag, link.mode};

  always_comb begin
    ctrl_next  = ctrl_reg;
    ev_next    = ev_reg;
    resp_next  = resp_reg;
    rdata_next = rdata_reg;
    pulse_next = 5'h0;
    dcmd_next  = dcmd_reg;
    done_next  = req && !done_reg;
    if (avs_read_in && !done_reg) begin
      unique case (avs_address_in)
        smpc_pkg::SMPC_OFS_CTRL:   rdata_next = ctrl_reg;
        smpc_pkg::SMPC_OFS_STATUS: rdata_next = status;
        smpc_pkg::SMPC_OFS_EVENT:  rdata_next = {29'h0, ev_reg};
        default:                   rdata_next = 32'h0;
      endcase
    end
    if (wr_go) begin
      unique case (avs_address_in)
        smpc_pkg::SMPC_OFS_CTRL: ctrl_next = avs_writedata_in;
        smpc_pkg::SMPC_OFS_CMD: begin
          pulse_next[0] = avs_writedata_in[smpc_pkg::SMPC_K_STOP];
          pulse_next[1] = avs_writedata_in[smpc_pkg::SMPC_K_ACK];
          pulse_next[2] = avs_writedata_in[smpc_pkg::SMPC_K_DBG];
          dcmd_next     = avs_writedata_in[smpc_pkg::SMPC_K_DBG_LSB +: 3];
        end
        smpc_pkg::SMPC_OFS_EVENT: ev_next = ev_reg & ~avs_writedata_in[2:0];
        default: ;
      endcase
    end
    // Device events set after the clear so they are never lost
    if (link.illegal_reset) begin
      ev_next[smpc_pkg::SMPC_E_ILLEGAL] = 1'b1;
    end
    if (link.dbg_resp_valid) begin
      ev_next[smpc_pkg::SMPC_E_RESP] = 1'b1;
      resp_next = {link.dbg_mem_access, link.dbg_resp_ok, link.dbg_resp_err};
    end
    if (link.vector_fetch) begin
      ev_next[smpc_pkg::SMPC_E_FETCH] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg  <= smpc_pkg::SMPC_CTRL_RST;
      ev_reg    <= 3'h0;
      resp_reg  <= 3'h0;
      rdata_reg <= 32'h0;
      pulse_reg <= 5'h0;
      dcmd_reg  <= 3'h0;
      done_reg  <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      ev_reg    <= ev_next;
      resp_reg  <= resp_next;
      rdata_reg <= rdata_next;
      pulse_reg <= pulse_next;
      dcmd_reg  <= dcmd_next;
      done_reg  <= done_next;
    end
  end

  assign avs_readdata_out              = rdata_reg;
  assign link.stop_exec                = pulse_reg[0];
  assign link.powerdown_acknowledge    = pulse_reg[1];
  assign link.dbg_cmd_valid            = pulse_reg[2];
  assign link.dbg_cmd                  = dcmd_reg;
  assign link.stop_allow_bit           = ctrl_reg[smpc_pkg::SMPC_C_STOP_ALLOW];
  assign link.debug_permit_bit         = ctrl_reg[smpc_pkg::SMPC_C_DBG_PERMIT];
  assign link.lowvolt_detect_on        = ctrl_reg[smpc_pkg::SMPC_C_LVD_ON];
  assign link.lowvolt_in_stop_on       = ctrl_reg[smpc_pkg::SMPC_C_LVD_STOP];
  assign link.powerdown_select         = ctrl_reg[smpc_pkg::SMPC_C_PD_SEL];
  assign link.partial_powerdown_select = ctrl_reg[smpc_pkg::SMPC_C_PPD_SEL];
  assign link.wakeup_pin               = ctrl_reg[smpc_pkg::SMPC_C_WAKE_PIN];
  assign link.reset_pin_n              = ctrl_reg[smpc_pkg::SMPC_C_RESET_PIN];
  assign link.supply_low               = ctrl_reg[smpc_pkg::SMPC_C_SUPPLY_LOW];
  assign link.wakeup_pin_pullup_on     = ctrl_reg[smpc_pkg::SMPC_C_PULLUP];
  assign link.irq_req = ctrl_reg[smpc_pkg::SMPC_C_IRQ_LSB +: smpc_pkg::SMPC_IRQ_N];
endmodule
`default_nettype wire

//--- verilog/smpc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface smpc_if;
  logic       stop_exec;
  logic       stop_allow_bit;
  logic       debug_permit_bit;
  logic       lowvolt_detect_on;
  logic       lowvolt_in_stop_on;
  logic       powerdown_select;
  logic       partial_powerdown_select;
  logic [4:0] irq_req;
  logic       reset_pin_n;
  logic       wakeup_pin;
  logic       wakeup_pin_pullup_on;
  logic       supply_low;
  logic       powerdown_acknowledge;
  logic       dbg_cmd_valid;
  logic [2:0] dbg_cmd;
  logic       illegal_reset;
  logic       cpu_clk_en;
  logic       bus_clk_en;
  logic       periph_clk_en;
  logic       debug_clk_en;
  logic       regulator_full;
  logic       ram_power;
  logic       io_latch_hold;
  logic       io_default;
  logic       por_reset;
  logic       lvr_low_trip;
  logic       pullup_out;
  logic       vector_fetch;
  logic [2:0] vector_sel;
  logic       partial_powerdown_wake_flag;
  logic       full_powerdown_wake_flag;
  logic [2:0] mode;
  logic       dbg_resp_valid;
  logic       dbg_resp_err;
  logic       dbg_resp_ok;
  logic       dbg_mem_access;

  modport dev (
    input  stop_exec, stop_allow_bit, debug_permit_bit, lowvolt_detect_on,
           lowvolt_in_stop_on, powerdown_select, partial_powerdown_select, irq_req,
           reset_pin_n, wakeup_pin, wakeup_pin_pullup_on, supply_low,
           powerdown_acknowledge, dbg_cmd_valid, dbg_cmd,
    output illegal_reset, cpu_clk_en, bus_clk_en, periph_clk_en, debug_clk_en,
           regulator_full, ram_power, io_latch_hold, io_default, por_reset,
           lvr_low_trip, pullup_out, vector_fetch, vector_sel,
           partial_powerdown_wake_flag, full_powerdown_wake_flag, mode,
           dbg_resp_valid, dbg_resp_err, dbg_resp_ok, dbg_mem_access
  );

  modport host (
    output stop_exec, stop_allow_bit, debug_permit_bit, lowvolt_detect_on,
           lowvolt_in_stop_on, powerdown_select, partial_powerdown_select, irq_req,
           reset_pin_n, wakeup_pin, wakeup_pin_pullup_on, supply_low,
           powerdown_acknowledge, dbg_cmd_valid, dbg_cmd,
    input  illegal_reset, cpu_clk_en, bus_clk_en, periph_clk_en, debug_clk_en,
           regulator_full, ram_power, io_latch_hold, io_default, por_reset,
           lvr_low_trip, pullup_out, vector_fetch, vector_sel,
           partial_powerdown_wake_flag, full_powerdown_wake_flag, mode,
           dbg_resp_valid, dbg_resp_err, dbg_resp_ok, dbg_mem_access
  );
endinterface
`default_nettype wire

//--- verilog/smpc_mode_sel.sv
`timescale 1ns/1ns
`default_nettype none
module smpc_mode_sel (
  input  wire logic          stop_allow_in,
  input  wire logic          debug_permit_in,
  input  wire logic          lvd_on_in,
  input  wire logic          lvd_stop_in,
  input  wire logic          pd_sel_in,
  input  wire logic          ppd_sel_in,
  output var smpc_pkg::smpc_mode_t mode_out
);
  always_comb begin
    if (!stop_allow_in) begin
      mode_out = smpc_pkg::SMPC_M_NONE;
    end else if (debug_permit_in) begin
      mode_out = smpc_pkg::SMPC_M_S3_DBG;
    end else if (lvd_on_in && lvd_stop_in) begin
      mode_out = smpc_pkg::SMPC_M_S3_REG;
    end else if (!pd_sel_in) begin
      mode_out = smpc_pkg::SMPC_M_S3;
    end else if (ppd_sel_in) begin
      mode_out = smpc_pkg::SMPC_M_S2;
    end else begin
      mode_out = smpc_pkg::SMPC_M_S1;
    end
  end
endmodule
`default_nettype wire

//--- verilog/smpc_pkg.sv
`default_nettype none
package smpc_pkg;

  typedef enum logic [2:0] {
    SMPC_M_NONE,
    SMPC_M_S3,
    SMPC_M_S3_DBG,
    SMPC_M_S3_REG,
    SMPC_M_S2,
    SMPC_M_S1
  } smpc_mode_t;

  typedef enum logic [2:0] {
    SMPC_RUN,
    SMPC_STOP3,
    SMPC_STOP2,
    SMPC_STOP1,
    SMPC_PORHOLD,
    SMPC_BKGD
  } smpc_state_t;

  // Debug command codes on the link
  localparam logic [2:0] SMPC_DCMD_MEM     = 3'h0;
  localparam logic [2:0] SMPC_DCMD_MEMSTAT = 3'h1;
  localparam logic [2:0] SMPC_DCMD_BKGD    = 3'h2;
  localparam logic [2:0] SMPC_DCMD_ACTIVE  = 3'h3;
  localparam logic [2:0] SMPC_DCMD_GO      = 3'h4;

  // Interrupt request positions, lowest index wins
  localparam int SMPC_IRQ_N   = 5;
  localparam int SMPC_IRQ_RTI = 0;
  localparam int SMPC_IRQ_LVD = 1;
  localparam int SMPC_IRQ_ADC = 2;
  localparam int SMPC_IRQ_EXT = 3;
  localparam int SMPC_IRQ_KEY = 4;

  // Vector select: reset, else interrupt index plus one
  localparam logic [2:0] SMPC_VEC_RESET = 3'h0;

  // Power-on style reset hold after stop1/stop2 wake
  localparam int         SMPC_CLK_NS      = 100;
  localparam int         SMPC_POR_HOLD_NS = 1000;
  localparam logic [3:0] SMPC_POR_CYC     =
    4'((SMPC_POR_HOLD_NS + SMPC_CLK_NS - 1) / SMPC_CLK_NS);

  // Controller register map, byte addresses
  localparam logic [3:0] SMPC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] SMPC_OFS_CMD    = 4'h4;
  localparam logic [3:0] SMPC_OFS_STATUS = 4'h8;
  localparam logic [3:0] SMPC_OFS_EVENT  = 4'hc;

  // CTRL fields
  localparam int SMPC_C_STOP_ALLOW = 0;
  localparam int SMPC_C_DBG_PERMIT = 1;
  localparam int SMPC_C_LVD_ON     = 2;
  localparam int SMPC_C_LVD_STOP   = 3;
  localparam int SMPC_C_PD_SEL     = 4;
  localparam int SMPC_C_PPD_SEL    = 5;
  localparam int SMPC_C_WAKE_PIN   = 6;
  localparam int SMPC_C_RESET_PIN  = 7;
  localparam int SMPC_C_SUPPLY_LOW = 8;
  localparam int SMPC_C_PULLUP     = 9;
  localparam int SMPC_C_IRQ_LSB    = 10;
  localparam logic [31:0] SMPC_CTRL_RST = 32'h0000_00c0;

  // CMD fields, write-only pulses
  localparam int SMPC_K_STOP    = 0;
  localparam int SMPC_K_ACK     = 1;
  localparam int SMPC_K_DBG     = 2;
  localparam int SMPC_K_DBG_LSB = 4;

  // EVENT fields, write one to clear
  localparam int SMPC_E_ILLEGAL = 0;
  localparam int SMPC_E_RESP    = 1;
  localparam int SMPC_E_FETCH   = 2;

endpackage
`default_nettype wire
